//--- src/cdb_countdown_top.sv
// countdown bar graph timing and timed audio silence insertion
`timescale 1ns/1ns

// How it works
// - bar climbs 0 to 10 then falls, one step per second
// - banner selector at D runs the countdown banner
// - bar is shown only while the mode selector is an overlay mode
// - markers for channels 2, 3 and 4 pulse at gap starts on the rise
// - channel 2 gaps need embed, link and countdown; 8 s then 12 s
// - channel 3 and 4 gaps ignore the pulsed audio link
// - channel 3 muted 0.375 s, 0.75 s into each 4 s interval
// - channel 4 muted twice 0.375 s, first at 0.75 s, same interval
// - four 20-bit channels at 48 kHz pass through, group 1 order
module cdb_countdown_top #(
    parameter int SPS = cdb_pkg::SAMPLE_RATE_HZ
) (
    // clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_i,
    // front panel and link settings
    input  wire logic [3:0]            banner_sel_i,
    input  wire logic [3:0]            mode_sel_i,
    input  wire logic                  audio_embed_en_i,
    input  wire logic                  pulsed_audio_link_i,
    // audio samples from the tone generator
    input  wire logic                  in_valid_i,
    input  wire logic [DW-1:0]         in_data_i,
    output wire logic                  in_ready_o,
    // audio samples toward the embedder
    output wire logic                  out_valid_o,
    output wire logic [DW-1:0]         out_data_o,
    input  wire logic                  out_ready_i,
    // banner drawing
    output logic                       bar_show_o,
    output logic [3:0]                 bar_level_o,
    output logic                       bar_rising_o,
    output logic [2:0]                 marker_o
);

    // ========================================================
    // derived widths and counts, in samples or seconds
    localparam int DW        = cdb_pkg::N_CH * cdb_pkg::CH_W;
    localparam int SUB_W     = $clog2(SPS);
    localparam int SEC_W     = $clog2(cdb_pkg::CYCLE_S);
    localparam int POS_W     = $clog2(cdb_pkg::CYCLE_S * SPS);
    localparam int GAP_LEN   = cdb_pkg::GAP_LEN_MS * SPS / 1000;
    localparam int GAP_OFS   = cdb_pkg::GAP_OFS_MS * SPS / 1000;
    localparam int CH4_SPACE = cdb_pkg::CH4_SPACE_MS * SPS / 1000;
    localparam int CH4_SECOND = GAP_OFS + GAP_LEN + CH4_SPACE;
    localparam int CH2_A_S   = cdb_pkg::CH2_FIRST_S;
    localparam int CH2_B_S   = cdb_pkg::CH2_FIRST_S + cdb_pkg::CH2_SHORT_S;

    // ========================================================
    // decode helpers
    function automatic logic in_win(input logic [POS_W-1:0] pos,
                                    input int               start);
        return (pos >= POS_W'(start)) && (pos < POS_W'(start + GAP_LEN));
    endfunction

    function automatic logic is_overlay(input logic [3:0] mode);
        return cdb_pkg::OVERLAY_MODES[mode];
    endfunction

    // ========================================================
    // streams around the buffer
    cdb_stream_if #(.W(DW)) up ();
    cdb_stream_if #(.W(DW)) dn ();

    cdb_skid_buf #(
        .W(DW)
    ) u_buf (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .in_s      (up),
        .out_s     (dn)
    );

    // ========================================================
    // sample timebase
    logic [SUB_W-1:0] sub_reg;
    logic [SUB_W-1:0] sub_next;
    logic [SEC_W-1:0] sec_reg;
    logic [SEC_W-1:0] sec_next;

    wire logic             run_w;
    wire logic             ovl_w;
    wire logic             accept;
    wire logic             sub_wrap;
    wire logic             sec_wrap;
    wire logic [POS_W-1:0] pos20;
    wire logic [POS_W-1:0] pos4;

    assign run_w    = banner_sel_i == cdb_pkg::BANNER_COUNTDOWN;
    assign ovl_w    = is_overlay(mode_sel_i);
    assign accept   = in_valid_i && up.ready;
    assign sub_wrap = sub_reg == SUB_W'(SPS - 1);
    assign sec_wrap = sec_reg == SEC_W'(cdb_pkg::CYCLE_S - 1);

    // time advances once per accepted sample
    assign sub_next = !run_w   ? '0 :
                      !accept  ? sub_reg :
                      sub_wrap ? '0 : sub_reg + SUB_W'(1);
    assign sec_next = !run_w               ? '0 :
                      !(accept && sub_wrap) ? sec_reg :
                      sec_wrap ? '0 : sec_reg + SEC_W'(1);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sub_reg <= '0;
            sec_reg <= '0;
        end else begin
            sub_reg <= sub_next;
            sec_reg <= sec_next;
        end
    end

    // position in the 20 s cycle and in the 4 s interval
    assign pos20 = POS_W'(sec_reg) * POS_W'(SPS) + POS_W'(sub_reg);
    assign pos4  = POS_W'(sec_reg % SEC_W'(cdb_pkg::INTERVAL_S))
                   * POS_W'(SPS) + POS_W'(sub_reg);

    // ========================================================
    // silence windows
    wire logic [2:0] win_w;
    wire logic [3:0] mute_w;
    wire logic [2:0] start_w;
    wire logic       rising_w;
    wire logic [3:0] level_w;
    logic      [2:0] win_prev_reg;
    logic      [2:0] win_prev_next;

    assign win_w[0] = in_win(pos20, CH2_A_S * SPS)
                    || in_win(pos20, CH2_B_S * SPS);
    assign win_w[1] = in_win(pos4, GAP_OFS);
    assign win_w[2] = in_win(pos4, GAP_OFS)
                    || in_win(pos4, CH4_SECOND);

    assign mute_w[0] = 1'b0;
    assign mute_w[1] = run_w && audio_embed_en_i && pulsed_audio_link_i
                       && win_w[0];
    assign mute_w[3:2] = {2{run_w && audio_embed_en_i}} & win_w[2:1];

    assign win_prev_next = !run_w ? 3'h0 : accept ? win_w : win_prev_reg;
    assign start_w       = {3{accept}} & win_w & ~win_prev_reg;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            win_prev_reg <= 3'h0;
        end else begin
            win_prev_reg <= win_prev_next;
        end
    end

    // ========================================================
    // muting of the sample words, channel 1 in the low bits
    wire logic [DW-1:0] muted_w;

    genvar g;
    generate
        for (g = 0; g < cdb_pkg::N_CH; g++) begin : g_ch
            assign muted_w[g*cdb_pkg::CH_W +: cdb_pkg::CH_W] =
                mute_w[g] ? '0
                          : in_data_i[g*cdb_pkg::CH_W +: cdb_pkg::CH_W];
        end
    endgenerate

    assign up.valid   = in_valid_i;
    assign up.data    = muted_w;
    assign in_ready_o = up.ready;

    assign dn.ready    = out_ready_i;
    assign out_valid_o = dn.valid;
    assign out_data_o  = dn.data;

    // ========================================================
    // bar graph and markers
    assign rising_w = sec_reg < SEC_W'(cdb_pkg::SCALE_TOP_S);
    assign level_w  = rising_w ? 4'(sec_reg)
                               : 4'(SEC_W'(cdb_pkg::CYCLE_S) - sec_reg);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            bar_show_o   <= 1'b0;
            bar_level_o  <= 4'h0;
            bar_rising_o <= 1'b1;
            marker_o     <= 3'h0;
        end else begin
            bar_show_o   <= run_w && ovl_w;
            bar_level_o  <= level_w;
            bar_rising_o <= rising_w;
            marker_o     <= start_w & {3{rising_w}};
        end
    end

    // ========================================================
    // assertions
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    sequence s_stall;
        dn.valid && !out_ready_i;
    endsequence

    sequence s_hold;
        dn.valid && $stable(dn.data);
    endsequence

    a_bar_range:
    assert property (bar_level_o <= 4'(cdb_pkg::SCALE_TOP_S))
        else $error("bar level beyond top of scale");

    a_bar_step:
    assert property ($past(run_w) && run_w && $changed(bar_level_o)
                     |-> (bar_level_o == $past(bar_level_o) + 4'h1)
                      || (bar_level_o == $past(bar_level_o) - 4'h1))
        else $error("bar level moved by more than one step");

    a_show_needs_d:
    assert property (bar_show_o
                     |-> $past(banner_sel_i) == cdb_pkg::BANNER_COUNTDOWN)
        else $error("bar shown without countdown banner");

    a_show_needs_ovl:
    assert property (run_w && !ovl_w |=> !bar_show_o)
        else $error("bar shown outside an overlay mode");

    a_marker_rise:
    assert property (|marker_o
                     |-> $past(sec_reg) < SEC_W'(cdb_pkg::SCALE_TOP_S))
        else $error("marker while bar falls");

    a_ch2_gate:
    assert property (accept && !(audio_embed_en_i && pulsed_audio_link_i)
                     |-> up.data[cdb_pkg::CH_W +: cdb_pkg::CH_W]
                      == in_data_i[cdb_pkg::CH_W +: cdb_pkg::CH_W])
        else $error("channel 2 muted without link and embed");

    a_ch2_start:
    assert property (start_w[0] |-> sub_reg == '0
                     && (sec_reg == SEC_W'(CH2_A_S)
                      || sec_reg == SEC_W'(CH2_B_S)))
        else $error("channel 2 gap at wrong second");

    a_ch3_no_link:
    assert property (accept && run_w && audio_embed_en_i
                     && !pulsed_audio_link_i && win_w[1]
                     |-> up.data[2*cdb_pkg::CH_W +: cdb_pkg::CH_W] == '0)
        else $error("channel 3 not muted without link");

    a_ch3_start:
    assert property (start_w[1] |-> pos4 == POS_W'(GAP_OFS)
                     ##1 win_w[1] || !$past(accept))
        else $error("channel 3 gap starts at wrong offset");

    a_ch4_start:
    assert property (start_w[2] |-> pos4 == POS_W'(GAP_OFS)
                     || pos4 == POS_W'(CH4_SECOND))
        else $error("channel 4 gap starts at wrong offset");

    a_count_adv:
    assert property (accept && run_w
                     |=> sub_reg == $past(sub_reg) + SUB_W'(1)
                      || (sub_reg == '0 && $past(sub_wrap)))
        else $error("sample counter did not advance");

    a_out_hold:
    assert property (s_stall |=> s_hold)
        else $error("output word changed while stalled");

endmodule

//--- src/cdb_pkg.sv
// shared constants of the countdown banner and audio sync marker
package cdb_pkg;

    // ========================================================
    // banner and mode selection
    localparam logic [3:0]  BANNER_COUNTDOWN = 4'hD;
    // one bit per mode switch position that overlays a banner
    localparam logic [15:0] OVERLAY_MODES    = 16'h00F0;

    // ========================================================
    // countdown scale, whole seconds
    localparam int SCALE_TOP_S = 10;
    localparam int CYCLE_S     = 2 * SCALE_TOP_S;

    // ========================================================
    // silence timing
    localparam int GAP_LEN_MS   = 375;
    localparam int GAP_OFS_MS   = 750;
    localparam int INTERVAL_S   = 4;
    localparam int CH4_SPACE_MS = 375;
    localparam int CH2_FIRST_S  = 1;
    localparam int CH2_SHORT_S  = 8;
    localparam int CH2_LONG_S   = 12;

    // ========================================================
    // embedded audio format
    localparam int SAMPLE_RATE_HZ = 48000;
    localparam int CH_W           = 20;
    localparam int N_CH           = 4;

endpackage

//--- src/cdb_stream_if.sv
// valid/ready word stream between the block's own modules
`timescale 1ns/1ns
interface cdb_stream_if #(
    parameter int W = 80
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- src/cdb_skid_buf.sv
// two-entry buffer with registered valid, data and ready
`timescale 1ns/1ns
module cdb_skid_buf #(
    parameter int W = 80
) (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    // streams
    cdb_stream_if.snk in_s,
    cdb_stream_if.src out_s
);

    // ========================================================
    // storage
    logic [W-1:0] head_reg;
    logic [W-1:0] head_next;
    logic         head_v_reg;
    logic         head_v_next;
    logic [W-1:0] spare_reg;
    logic [W-1:0] spare_next;
    logic         spare_v_reg;
    logic         spare_v_next;

    wire logic push;
    wire logic free_head;

    assign push      = in_s.valid && !spare_v_reg;
    assign free_head = !head_v_reg || out_s.ready;

    // head refills from the spare first so word order holds
    assign head_next    = !free_head   ? head_reg  :
                          spare_v_reg  ? spare_reg : in_s.data;
    assign head_v_next  = !free_head || spare_v_reg || push;
    assign spare_next   = push ? in_s.data : spare_reg;
    assign spare_v_next = free_head ? (spare_v_reg && push)
                                    : (spare_v_reg || push);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            head_reg    <= '0;
            head_v_reg  <= 1'b0;
            spare_reg   <= '0;
            spare_v_reg <= 1'b0;
        end else begin
            head_reg    <= head_next;
            head_v_reg  <= head_v_next;
            spare_reg   <= spare_next;
            spare_v_reg <= spare_v_next;
        end
    end

    // ========================================================
    // ports
    assign out_s.valid = head_v_reg;
    assign out_s.data  = head_reg;
    assign in_s.ready  = !spare_v_reg;

endmodule

//--- tb/cdb_sink_model.sv
// downstream receiver model: ready prompt, one cycle in three, or held off
`timescale 1ns/1ns
module cdb_sink_model (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    // ready pattern: 0 prompt, 1 one cycle in three, 2 held off
    input  wire logic [1:0] stall_mode_i,
    // stream handshake toward the block
    output logic            ready_o
);
    // ========================================================
    // ready pattern
    logic [1:0] phase_reg;
    logic [1:0] phase_next;
    logic       ready_next;

    assign phase_next = (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
    assign ready_next = (stall_mode_i == 2'h0) ||
                        (stall_mode_i == 2'h1 && phase_next == 2'h0);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            phase_reg <= 2'h0;
            ready_o   <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            ready_o   <= ready_next;
        end
    end
endmodule

//--- tb/countdown_banner_audio_sync_marker_tb.sv
// self-checking bench of the countdown bar and audio silence timing
`timescale 1ns/1ns
module countdown_banner_audio_sync_marker_tb;
    // ========================================================
    // timing in samples, shortened second
    localparam int SPS = 40;
    localparam int CYC = cdb_pkg::CYCLE_S * SPS;
    localparam int GAP = cdb_pkg::GAP_LEN_MS * SPS / 1000;
    localparam int OFS = cdb_pkg::GAP_OFS_MS * SPS / 1000;
    localparam int ITV = cdb_pkg::INTERVAL_S * SPS;
    localparam int SPC = cdb_pkg::CH4_SPACE_MS * SPS / 1000;
    localparam int C2A = cdb_pkg::CH2_FIRST_S * SPS;
    localparam int C2B = C2A + cdb_pkg::CH2_SHORT_S * SPS;

    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  banner_sel_i = 4'h0;
    logic [3:0]  mode_sel_i = 4'h0;
    logic        audio_embed_en_i = 1'b0;
    logic        pulsed_audio_link_i = 1'b0;
    logic        in_valid_i = 1'b0;
    logic [79:0] in_data_i = 80'h0;
    logic        in_ready_o, out_valid_o, out_ready_i;
    logic [79:0] out_data_o;
    logic        bar_show_o, bar_rising_o;
    logic [3:0]  bar_level_o;
    logic [2:0]  marker_o, mm;
    logic [1:0]  stall_mode = 2'h0;
    logic [79:0] exp_w;
    logic        m_d, m_embed, m_link;
    int          errors = 0, n_checks = 0, rx_k = 0, sent_n = 0;
    int          mk_cnt [3];
    int          max_lvl;

    always #20 clk_sys_i = ~clk_sys_i;

    cdb_countdown_top #(.SPS(SPS)) dut_u (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .banner_sel_i(banner_sel_i), .mode_sel_i(mode_sel_i),
        .audio_embed_en_i(audio_embed_en_i),
        .pulsed_audio_link_i(pulsed_audio_link_i),
        .in_valid_i(in_valid_i), .in_data_i(in_data_i),
        .in_ready_o(in_ready_o), .out_valid_o(out_valid_o),
        .out_data_o(out_data_o), .out_ready_i(out_ready_i),
        .bar_show_o(bar_show_o), .bar_level_o(bar_level_o),
        .bar_rising_o(bar_rising_o), .marker_o(marker_o));

    cdb_sink_model sink_u (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .stall_mode_i(stall_mode), .ready_o(out_ready_i));

    // ========================================================
    // expectations
    function automatic logic [79:0] word(input int k);
        logic [79:0] w;
        for (int c = 0; c < 4; c++) w[c*20+:20] = {k[15:0], c[3:0] + 4'h1};
        return w;
    endfunction

    // ungated gaps of ch4, ch3, ch2 for cycle position k
    function automatic logic [2:0] raw_gap(input int k);
        int p, ip;
        logic g3;
        p = k % CYC;
        ip = p % ITV;
        g3 = ip >= OFS && ip < OFS + GAP;
        return {g3 || (ip >= OFS + GAP + SPC && ip < OFS + 2 * GAP + SPC), g3,
                (p >= C2A && p < C2A + GAP) || (p >= C2B && p < C2B + GAP)};
    endfunction

    function automatic int rise_starts(input int b);
        int n;
        n = 0;
        for (int p = 1; p < CYC / 2; p++) if (raw_gap(p)[b] && !raw_gap(p-1)[b]) n++;
        return n;
    endfunction

    // ========================================================
    // reporting
    task automatic check(input string what, input logic [79:0] exp,
                         input logic [79:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ========================================================
    // receive side monitor, sampled mid-cycle
    always @(negedge clk_sys_i) begin
        if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
            exp_w = word(rx_k);
            mm = raw_gap(rx_k) & {m_d && m_embed, m_d && m_embed,
                                  m_d && m_embed && m_link};
            for (int c = 0; c < 3; c++) if (mm[c]) exp_w[(c+1)*20+:20] = 20'h0;
            check("out_data_o", exp_w, out_data_o);
            rx_k++;
        end
        for (int i = 0; i < 3; i++) if (marker_o[i] === 1'b1) mk_cnt[i]++;
        if (bar_level_o > max_lvl) max_lvl = bar_level_o;
    end

    // ========================================================
    // drivers
    task automatic restart(input logic [3:0] b, input logic e, input logic l,
                           input logic [3:0] m);
        banner_sel_i = 4'h0;
        repeat (3) @(posedge clk_sys_i);
        #1;
        banner_sel_i = b;
        audio_embed_en_i = e;
        pulsed_audio_link_i = l;
        mode_sel_i = m;
        m_d = (b == cdb_pkg::BANNER_COUNTDOWN);
        m_embed = e;
        m_link = l;
        rx_k = 0;
        sent_n = 0;
        mk_cnt = '{0, 0, 0};
        max_lvl = 0;
    endtask

    task automatic send(input int n);
        int k, waitc;
        logic rdy;
        k = 0;
        waitc = 0;
        while (k < n) begin
            in_valid_i = 1'b1;
            in_data_i = word(sent_n + k);
            rdy = in_ready_o;
            @(posedge clk_sys_i);
            #1;
            if (rdy === 1'b1) begin
                k++;
                waitc = 0;
            end else if (++waitc > 200) begin
                errors++;
                $display("Error in_ready_o stuck low");
                end_sim();
            end
        end
        in_valid_i = 1'b0;
        sent_n += n;
    endtask

    task automatic drain();
        int i;
        i = 0;
        while (rx_k != sent_n && i < 500) begin
            @(posedge clk_sys_i);
            i++;
        end
        if (rx_k != sent_n) begin
            errors++;
            $display("Error words lost expected %0d seen %0d", sent_n, rx_k);
            end_sim();
        end
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask

    // ========================================================
    // scenarios
    task automatic sc_passthru();
        restart(4'h0, 1'b1, 1'b1, 4'h4);
        send(200);
        drain();
        check("bar_show_o", 0, bar_show_o);
        check("bar_level_o", 0, max_lvl);
        check("markers", 0, mk_cnt[0] + mk_cnt[1] + mk_cnt[2]);
    endtask

    task automatic sc_full_cycle();
        int i;
        restart(cdb_pkg::BANNER_COUNTDOWN, 1'b1, 1'b1, 4'h4);
        stall_mode = 2'h2;
        i = 0;
        fork
            send(CYC);
            begin
                while (in_ready_o !== 1'b0 && i < 50) begin
                    @(posedge clk_sys_i);
                    #1;
                    i++;
                end
                // buffer full must refuse further words
                check("in_ready_o", 0, in_ready_o);
                stall_mode = 2'h1;
            end
        join
        drain();
        stall_mode = 2'h0;
        check("bar_show_o", 1, bar_show_o);
        check("bar_max", cdb_pkg::SCALE_TOP_S, max_lvl);
        check("bar_level_o", 0, bar_level_o);
        check("bar_rising_o", 1, bar_rising_o);
        for (int b = 0; b < 3; b++) check("marker_o", rise_starts(b), mk_cnt[b]);
    endtask

    task automatic sc_no_link();
        restart(cdb_pkg::BANNER_COUNTDOWN, 1'b1, 1'b0, 4'h3);
        send(CYC / 2 + SPS);
        drain();
        check("bar_show_o", 0, bar_show_o);
        check("bar_level_o", 2 * cdb_pkg::SCALE_TOP_S - (CYC / 2 + SPS) / SPS, bar_level_o);
        check("bar_rising_o", 0, bar_rising_o);
        for (int b = 0; b < 3; b++) check("marker_o", rise_starts(b), mk_cnt[b]);
    endtask

    task automatic sc_no_embed();
        restart(cdb_pkg::BANNER_COUNTDOWN, 1'b0, 1'b1, 4'h7);
        send(5 * SPS);
        drain();
        check("bar_show_o", 1, bar_show_o);
        check("bar_level_o", 5, bar_level_o);
        check("bar_rising_o", 1, bar_rising_o);
    endtask

    // ========================================================
    // main sequence
    initial begin
        m_d = 1'b0;
        m_embed = 1'b0;
        m_link = 1'b0;
        mk_cnt = '{0, 0, 0};
        max_lvl = 0;
        repeat (8) @(posedge clk_sys_i);
        #1;
        rst_i = 1'b0;
        sc_passthru();
        sc_full_cycle();
        sc_no_link();
        sc_no_embed();
        end_sim();
    end
endmodule
